// File: src/cmpsync_regs.svh
// Register offsets, field positions and reset values of the comparator sync block
`ifndef CMPSYNC_REGS_SVH
`define CMPSYNC_REGS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define CMPSYNC_OFS_LINK 12'h000
`define CMPSYNC_OFS_REFSEL 12'h004
`define CMPSYNC_OFS_AUX 12'h008
`define CMPSYNC_OFS_STATUS 12'h00C

// ==========================================================================
// comparator_timer_link_control fields
// ==========================================================================
`define CMPSYNC_LINK_SYNC 0
`define CMPSYNC_LINK_GSS 1
`define CMPSYNC_LINK_HYS 3
`define CMPSYNC_LINK_TCS 4
`define CMPSYNC_LINK_MASK 8'h1B
`define CMPSYNC_LINK_RESET 8'h00

// ==========================================================================
// reference_select_control fields
// ==========================================================================
`define CMPSYNC_REF_LEVEL_LSB 0
`define CMPSYNC_REF_LEVEL_MSB 3
`define CMPSYNC_REF_FIXED 4
`define CMPSYNC_REF_RANGE 5
`define CMPSYNC_REF_MUX 7
`define CMPSYNC_REF_MASK 8'hBF
`define CMPSYNC_REF_RESET 8'h00

// ==========================================================================
// Auxiliary control fields
// ==========================================================================
`define CMPSYNC_AUX_LADDER_EN 0
`define CMPSYNC_AUX_PRESC_LSB 1
`define CMPSYNC_AUX_PRESC_MSB 2
`define CMPSYNC_AUX_MASK 8'h07
`define CMPSYNC_AUX_RESET 8'h00

// ==========================================================================
// Status fields
// ==========================================================================
`define CMPSYNC_STAT_RAW 0
`define CMPSYNC_STAT_RESULT 1
`define CMPSYNC_STAT_SYNCED 2
`define CMPSYNC_STAT_GATE 3
`define CMPSYNC_STAT_FIXED_ON 4
`define CMPSYNC_STAT_LADDER_ON 5

// ==========================================================================
// Ladder fraction in 1/96 of supply
// ==========================================================================
`define CMPSYNC_LOW_STEP 8'h04
`define CMPSYNC_HIGH_BASE 8'h18
`define CMPSYNC_HIGH_STEP 8'h03

// Instruction clock runs at one quarter of the oscillator rate
`define CMPSYNC_INSTR_RATIO 8'h04

`endif

// File: src/cmpsync_pkg.sv
// Types shared by the comparator sync block
package cmpsync_pkg;

   typedef enum logic [1:0] {
      cmpsync_ref_ground,
      cmpsync_ref_ladder,
      cmpsync_ref_fixed
   } cmpsync_ref_source_type;

   typedef logic [7:0] cmpsync_byte_type;

endpackage : cmpsync_pkg

// File: src/cmpsync_timer_if.sv
// Signals between the control top and the timer sync unit
`timescale 1ns/1ps
interface cmpsync_timer_if;
   logic sync_enable;
   logic timer_clock_select;
   logic [1:0] prescale_select;
   logic gate_source_select;
   logic comparator_result;
   logic external_gate_pin;
   logic synced_result;
   logic gate_level;
   logic timer_rise;
   logic timer_fall;
   logic timer_increment;

   modport ctrl (
      output sync_enable,
      output timer_clock_select,
      output prescale_select,
      output gate_source_select,
      output comparator_result,
      output external_gate_pin,
      input synced_result,
      input gate_level,
      input timer_rise,
      input timer_fall,
      input timer_increment
   );

   modport unit (
      input sync_enable,
      input timer_clock_select,
      input prescale_select,
      input gate_source_select,
      input comparator_result,
      input external_gate_pin,
      output synced_result,
      output gate_level,
      output timer_rise,
      output timer_fall,
      output timer_increment
   );
endinterface : cmpsync_timer_if

// File: src/cmpsync_timer_sync.sv
// Timer clock edges, comparator sync latch and gate routing
`timescale 1ns/1ps
`include "cmpsync_regs.svh"
module cmpsync_timer_sync
   import cmpsync_pkg::*;
#(
   parameter int FOSC_DIV = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to control top
   cmpsync_timer_if.unit link
);

   localparam logic [7:0] FOSC_PERIOD = 8'(FOSC_DIV);

   logic [7:0] phase;
   logic [7:0] next_phase;
   logic latched;
   logic next_latched;
   logic [7:0] period;
   logic [7:0] half;

   // ========================================================================
   // Timer clock period in pclk cycles
   // ========================================================================
   always_comb begin
      logic [7:0] src;
      src = link.timer_clock_select ? FOSC_PERIOD
                                    : 8'(FOSC_PERIOD * `CMPSYNC_INSTR_RATIO);
      period = 8'(src << link.prescale_select);
      half = period >> 1;
   end

   always_comb begin
      if (phase >= 8'(period - 8'h01)) begin
         next_phase = 8'h00;
      end else begin
         next_phase = 8'(phase + 8'h01);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 8'h00;
      end else begin
         phase <= next_phase;
      end
   end

   // Rising edge counts, falling edge samples: no race
   assign link.timer_rise = (phase == 8'h00);
   assign link.timer_fall = (phase == half);

   // ========================================================================
   // Sync latch
   // ========================================================================
   always_comb begin
      next_latched = latched;
      if (link.timer_fall) begin
         next_latched = link.comparator_result;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched <= 1'b0;
      end else begin
         latched <= next_latched;
      end
   end

   assign link.synced_result = link.sync_enable ? latched : link.comparator_result;
   assign link.gate_level = link.gate_source_select ? link.external_gate_pin
                                                    : link.synced_result;
   assign link.timer_increment = link.timer_rise & link.gate_level;

endmodule : cmpsync_timer_sync

// File: src/cmpsync_top.sv
// Comparator sync, hysteresis and reference control with an APB register port
// Operation
// - Sync bit latches result on timer falling edge
// - Latch uses prescaled timer clock
// - Timer counts rising, latch samples falling edge
// - Clock select: 1 oscillator, 0 quarter rate
// - Hysteresis bit enables comparator hysteresis
// - Gate select: 1 external pin, 0 comparator
// - Unimplemented control bits ignore writes, read zero
// - Ladder has its own enable, ANDed with mux bit
// - Range bit picks low or high, 16 taps
// - Low level/24, high quarter plus level/32
// - Ladder off, low, level zero: ground
// - Fixed reference on by bit or fast oscillator
// - Mux bit with enable powers ladder, routes ladder or fixed
// - Mux and fixed bits low: reference grounded
// - Hysteresis: rise above upper, fall below lower
`timescale 1ns/1ps
`include "cmpsync_regs.svh"
module cmpsync_top
   import cmpsync_pkg::*;
#(
   parameter int FOSC_DIV = 2,
   parameter bit GATE_SOURCE_RESET = 1'b1
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparator side
   input wire logic comparator_raw,
   input wire logic comparator_above_upper,
   input wire logic comparator_below_lower,
   output logic hysteresis_enable,
   // Gate timer side
   input wire logic external_gate_pin,
   output logic gate_level,
   output logic timer_increment,
   output logic comparator_synced,
   // Reference block
   input wire logic fast_internal_oscillator,
   output logic ladder_power,
   output logic [7:0] ladder_fraction,
   output logic fixed_reference_on,
   output cmpsync_ref_source_type comparator_reference_in
);

   localparam logic [7:0] LINK_RESET =
      `CMPSYNC_LINK_RESET | (8'(GATE_SOURCE_RESET) << `CMPSYNC_LINK_GSS);

   cmpsync_byte_type link_ctrl;
   cmpsync_byte_type next_link_ctrl;
   cmpsync_byte_type ref_ctrl;
   cmpsync_byte_type next_ref_ctrl;
   cmpsync_byte_type aux_ctrl;
   cmpsync_byte_type next_aux_ctrl;
   logic hys_state;
   logic next_hys_state;
   logic comparator_result;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [7:0] status;
   logic [3:0] level;
   logic range_low;
   logic mux_ladder;
   logic fixed_bit;

   cmpsync_timer_if tlink ();

   // ========================================================================
   // APB access decode
   // ========================================================================
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   always_comb begin
      unique case (paddr)
         `CMPSYNC_OFS_LINK, `CMPSYNC_OFS_REFSEL,
         `CMPSYNC_OFS_AUX, `CMPSYNC_OFS_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // ========================================================================
   // Control registers
   // ========================================================================
   always_comb begin
      next_link_ctrl = link_ctrl;
      next_ref_ctrl = ref_ctrl;
      next_aux_ctrl = aux_ctrl;
      if (wr_en && pstrb[0]) begin
         unique case (paddr)
            `CMPSYNC_OFS_LINK: begin
               next_link_ctrl = pwdata[7:0] & `CMPSYNC_LINK_MASK;
            end
            `CMPSYNC_OFS_REFSEL: begin
               next_ref_ctrl = pwdata[7:0] & `CMPSYNC_REF_MASK;
            end
            `CMPSYNC_OFS_AUX: begin
               next_aux_ctrl = pwdata[7:0] & `CMPSYNC_AUX_MASK;
            end
            default: begin
               next_link_ctrl = link_ctrl;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_ctrl <= LINK_RESET;
         ref_ctrl <= `CMPSYNC_REF_RESET;
         aux_ctrl <= `CMPSYNC_AUX_RESET;
      end else begin
         link_ctrl <= next_link_ctrl;
         ref_ctrl <= next_ref_ctrl;
         aux_ctrl <= next_aux_ctrl;
      end
   end

   // ========================================================================
   // Read data and error, captured in the setup cycle
   // ========================================================================
   always_comb begin
      next_prdata = prdata;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pslverr = ~hit;
         next_prdata = 32'h0000_0000;
         if (rd_en) begin
            unique case (paddr)
               `CMPSYNC_OFS_LINK: next_prdata = {24'h00_0000, link_ctrl};
               `CMPSYNC_OFS_REFSEL: next_prdata = {24'h00_0000, ref_ctrl};
               `CMPSYNC_OFS_AUX: next_prdata = {24'h00_0000, aux_ctrl};
               `CMPSYNC_OFS_STATUS: next_prdata = {24'h00_0000, status};
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end else if (psel && penable) begin
         next_pslverr = pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ========================================================================
   // Hysteresis
   // ========================================================================
   assign hysteresis_enable = link_ctrl[`CMPSYNC_LINK_HYS];

   always_comb begin
      next_hys_state = hys_state;
      if (comparator_above_upper) begin
         next_hys_state = 1'b1;
      end else if (comparator_below_lower) begin
         next_hys_state = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hys_state <= 1'b0;
      end else begin
         hys_state <= next_hys_state;
      end
   end

   assign comparator_result = hysteresis_enable ? hys_state : comparator_raw;

   // ========================================================================
   // Timer sync unit
   // ========================================================================
   assign tlink.sync_enable = link_ctrl[`CMPSYNC_LINK_SYNC];
   assign tlink.timer_clock_select = link_ctrl[`CMPSYNC_LINK_TCS];
   assign tlink.prescale_select = aux_ctrl[`CMPSYNC_AUX_PRESC_MSB:`CMPSYNC_AUX_PRESC_LSB];
   assign tlink.gate_source_select = link_ctrl[`CMPSYNC_LINK_GSS];
   assign tlink.comparator_result = comparator_result;
   assign tlink.external_gate_pin = external_gate_pin;

   cmpsync_timer_sync #(
      .FOSC_DIV(FOSC_DIV)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .link(tlink.unit)
   );

   assign gate_level = tlink.gate_level;
   assign timer_increment = tlink.timer_increment;
   assign comparator_synced = tlink.synced_result;

   // ========================================================================
   // Reference control
   // ========================================================================
   assign level = ref_ctrl[`CMPSYNC_REF_LEVEL_MSB:`CMPSYNC_REF_LEVEL_LSB];
   assign range_low = ref_ctrl[`CMPSYNC_REF_RANGE];
   assign mux_ladder = ref_ctrl[`CMPSYNC_REF_MUX];
   assign fixed_bit = ref_ctrl[`CMPSYNC_REF_FIXED];

   // Ladder draws current only when enabled and selected
   assign ladder_power = aux_ctrl[`CMPSYNC_AUX_LADDER_EN] & mux_ladder;
   assign fixed_reference_on = fixed_bit | fast_internal_oscillator;

   always_comb begin
      if (!ladder_power) begin
         ladder_fraction = 8'h00;
      end else if (range_low) begin
         ladder_fraction = 8'(`CMPSYNC_LOW_STEP * level);
      end else begin
         ladder_fraction = 8'(`CMPSYNC_HIGH_BASE + `CMPSYNC_HIGH_STEP * level);
      end
   end

   always_comb begin
      if (mux_ladder) begin
         comparator_reference_in = cmpsync_ref_ladder;
      end else if (fixed_bit) begin
         // Fast oscillator powers the fixed reference but does not route it
         comparator_reference_in = cmpsync_ref_fixed;
      end else begin
         comparator_reference_in = cmpsync_ref_ground;
      end
   end

   // ========================================================================
   // Status
   // ========================================================================
   always_comb begin
      status = 8'h00;
      status[`CMPSYNC_STAT_RAW] = comparator_raw;
      status[`CMPSYNC_STAT_RESULT] = comparator_result;
      status[`CMPSYNC_STAT_SYNCED] = tlink.synced_result;
      status[`CMPSYNC_STAT_GATE] = tlink.gate_level;
      status[`CMPSYNC_STAT_FIXED_ON] = fixed_reference_on;
      status[`CMPSYNC_STAT_LADDER_ON] = ladder_power;
   end

endmodule : cmpsync_top

// File: testbench/cmpsync_assertions.sv
// Port checks for the comparator sync block
`timescale 1ns/1ps
module cmpsync_assertions
   import cmpsync_pkg::*;
#(
   parameter bit GATE_SOURCE_RESET = 1'b1
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   // Comparator, timer and reference
   input wire logic comparator_raw,
   input wire logic hysteresis_enable,
   input wire logic external_gate_pin,
   input wire logic gate_level,
   input wire logic timer_increment,
   input wire logic comparator_synced,
   input wire logic fast_internal_oscillator,
   input wire logic ladder_power,
   input wire logic [7:0] ladder_fraction,
   input wire logic fixed_reference_on,
   input wire cmpsync_ref_source_type comparator_reference_in
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Shadows of the link and reference select control registers
   logic [7:0] link_m;
   logic [7:0] next_link_m;
   logic [7:0] ref_m;
   logic [7:0] next_ref_m;
   always_comb begin
      next_link_m = link_m;
      next_ref_m = ref_m;
      if (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]) begin
         next_link_m = pwdata[7:0] & 8'h1B;
      end
      if (psel && penable && pwrite && paddr == 12'h004 && pstrb[0]) begin
         next_ref_m = pwdata[7:0] & 8'hBF;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_m <= {6'h00, GATE_SOURCE_RESET, 1'b0};
         ref_m <= 8'h00;
      end else begin
         link_m <= next_link_m;
         ref_m <= next_ref_m;
      end
   end
   // ==========================================================
   // Assertions
   AST_HYS_BIT: assert property (hysteresis_enable == link_m[3])
      else $error("hysteresis output differs from control bit");
   AST_GATE_ROUTE: assert property
      (gate_level == (link_m[1] ? external_gate_pin : comparator_synced))
      else $error("gate level not from selected source");
   AST_PASS: assert property
      (!link_m[0] && !link_m[3] |-> comparator_synced == comparator_raw)
      else $error("unsynced result differs from comparator");
   AST_SYNC_HOLD: assert property
      (link_m[0] && timer_increment ##1 link_m[0] |-> $stable(comparator_synced))
      else $error("synced result moved at timer rising edge");
   AST_INC_GATED: assert property (timer_increment |-> gate_level)
      else $error("timer counted with gate closed");
   AST_INC_SINGLE: assert property (timer_increment |=> !timer_increment)
      else $error("timer increment longer than one cycle");
   AST_FIXED_FORCED: assert property (fast_internal_oscillator |-> fixed_reference_on)
      else $error("fixed reference off with fast oscillator running");
   AST_LADDER_ROUTE: assert property
      (ladder_power |-> comparator_reference_in == cmpsync_ref_ladder)
      else $error("powered ladder not routed");
   AST_GROUND: assert property
      (!ref_m[7] && !ref_m[4] |-> comparator_reference_in == cmpsync_ref_ground)
      else $error("reference not grounded with mux and fixed bits low");
   AST_FIXED_ROUTE: assert property
      (!ref_m[7] && ref_m[4] |-> comparator_reference_in == cmpsync_ref_fixed)
      else $error("fixed reference not routed with mux bit low");
   AST_LADDER_OFF: assert property (!ladder_power |-> ladder_fraction == 8'h00)
      else $error("unpowered ladder not at ground");
   AST_TAP_SET: assert property (ladder_power |->
      (ladder_fraction[1:0] == 2'h0 && ladder_fraction <= 8'h3C) ||
      (ladder_fraction >= 8'h18 && ladder_fraction <= 8'h45 &&
      (ladder_fraction - 8'h18) % 3 == 0))
      else $error("ladder fraction outside tap set");
   AST_RSVD_ZERO: assert property
      (psel && penable && !pwrite && paddr == 12'h000 |-> (prdata & 32'hFFFFFFE4) == 32'h0)
      else $error("unimplemented control bits read nonzero");
   COV_SYNC_INC: cover property (link_m[0] && timer_increment);
   COV_LADDER: cover property (comparator_reference_in == cmpsync_ref_ladder);
   COV_FORCED: cover property (fast_internal_oscillator && fixed_reference_on);
endmodule : cmpsync_assertions

bind cmpsync_top cmpsync_assertions #(.GATE_SOURCE_RESET(GATE_SOURCE_RESET))
   cmpsync_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .prdata, .comparator_raw, .hysteresis_enable, .external_gate_pin,
   .gate_level, .timer_increment, .comparator_synced, .fast_internal_oscillator,
   .ladder_power, .ladder_fraction, .fixed_reference_on, .comparator_reference_in);

// File: testbench/cmpsync_gate_timer_model.sv
// Gate timer model counting the block's increments
`timescale 1ns/1ps
module cmpsync_gate_timer_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // From the block
   input wire logic timer_increment,
   // Timer value
   output logic [15:0] count
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
      end else if (timer_increment) begin
         count <= count + 16'h0001;
      end
   end
endmodule : cmpsync_gate_timer_model

// File: testbench/testbench.sv
// Self-checking bench for the comparator sync block
`timescale 1ns/1ps
module testbench;
   import cmpsync_pkg::*;
   localparam int FDIV = 2;
   localparam bit GSR = 1'b1;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic comparator_raw = 1'b0, comparator_above_upper = 1'b0, comparator_below_lower = 1'b0;
   logic external_gate_pin = 1'b0, fast_internal_oscillator = 1'b0;
   logic [31:0] prdata, r;
   logic pready, pslverr, hysteresis_enable, gate_level, timer_increment, e;
   logic comparator_synced, ladder_power, fixed_reference_on;
   logic [7:0] ladder_fraction, rf, ax;
   logic [7:0] corner [4] = '{8'h20, 8'hAF, 8'h8F, 8'h10};
   cmpsync_ref_source_type comparator_reference_in;
   logic [15:0] count, c0;
   int p, cycles = 0, checks = 0, errors = 0, seed;

   cmpsync_top #(.FOSC_DIV(FDIV), .GATE_SOURCE_RESET(GSR)) cmpsync_top_i (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .comparator_raw, .comparator_above_upper, .comparator_below_lower, .hysteresis_enable,
      .external_gate_pin, .gate_level, .timer_increment, .comparator_synced,
      .fast_internal_oscillator, .ladder_power, .ladder_fraction, .fixed_reference_on,
      .comparator_reference_in);
   cmpsync_gate_timer_model cmpsync_gate_timer_model_i (.pclk, .presetn, .timer_increment,
      .count);

   always #10 pclk = ~pclk;

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'hF, r, e);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 8'h00, 4'hF, r, e);
      cmp(r, x);
      cmp({31'h0, e}, {31'h0, xe});
   endtask : rd_chk

   task automatic wait_inc;
      int n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (timer_increment !== 1'b1 && n < 200);
      cmp({31'h0, timer_increment}, 32'h1);
   endtask : wait_inc

   function automatic logic [7:0] exp_frac(input logic [7:0] f, input logic [7:0] x);
      if (!(f[7] && x[0])) return 8'h00;
      return f[5] ? {2'h0, f[3:0], 2'h0} : 8'h18 + 8'h03 * {4'h0, f[3:0]};
   endfunction : exp_frac

   function automatic logic [1:0] exp_src(input logic [7:0] f);
      return f[7] ? 2'h1 : (f[4] ? 2'h2 : 2'h0);
   endfunction : exp_src

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   initial begin
      seed = 32'hB95453AE;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // ==========================================================
      // Registers
      rd_chk(12'h000, {30'h0, GSR, 1'b0}, 1'b0);
      rd_chk(12'h004, 32'h0, 1'b0);
      rd_chk(12'h010, 32'h0, 1'b1);
      wr(12'h000, 8'hFF);
      rd_chk(12'h000, 32'h1B, 1'b0);
      apb(1'b1, 12'h000, 8'h00, 4'hE, r, e);
      rd_chk(12'h000, 32'h1B, 1'b0);
      wr(12'h004, 8'hFF);
      rd_chk(12'h004, 32'hBF, 1'b0);
      $display("test registers done");
      // ==========================================================
      // Reference selection
      for (int i = 0; i < 40; i++) begin
         rf = (i < 4) ? corner[i] : 8'($random(seed));
         ax = (i < 4) ? 8'h01 : 8'($random(seed));
         fast_internal_oscillator <= 1'($random(seed));
         comparator_raw <= 1'($random(seed));
         wr(12'h004, rf);
         wr(12'h008, ax);
         repeat (2) @(negedge pclk);
         cmp({24'h0, ladder_fraction}, {24'h0, exp_frac(rf, ax)});
         cmp({31'h0, ladder_power}, {31'h0, rf[7] & ax[0]});
         cmp({31'h0, fixed_reference_on}, {31'h0, rf[4] | fast_internal_oscillator});
         cmp({30'h0, comparator_reference_in}, {30'h0, exp_src(rf)});
         @(posedge pclk);
      end
      $display("test reference done");
      // ==========================================================
      // Timer clock and prescale
      comparator_raw <= 1'b0;
      external_gate_pin <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         wr(12'h000, {3'h0, k[2], 4'h2});
         wr(12'h008, {5'h00, k[1:0], 1'b0});
         p = (FDIV * (k[2] ? 1 : 4)) << k[1:0];
         wait_inc();
         c0 = count;
         repeat (4 * p) @(negedge pclk);
         cmp({16'h0, count - c0}, 32'h4);
         @(posedge pclk);
      end
      external_gate_pin <= 1'b0;
      @(negedge pclk);
      c0 = count;
      repeat (100) @(negedge pclk);
      cmp({16'h0, count - c0}, 32'h0);
      $display("test timer done");
      // ==========================================================
      // Sync latch on falling timer edge, prescaled
      @(posedge pclk);
      external_gate_pin <= 1'b1;
      wr(12'h000, 8'h13);
      wr(12'h008, 8'h06);
      wait_inc();
      @(posedge pclk);
      comparator_raw <= 1'b1;
      repeat (3) @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h0);
      repeat (8) @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h1);
      @(posedge pclk);
      wr(12'h000, 8'h11);
      wait_inc();
      @(posedge pclk);
      wr(12'h000, 8'h00);
      comparator_raw <= 1'b0;
      @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h0);
      $display("test sync done");
      // ==========================================================
      // Hysteresis
      @(posedge pclk);
      wr(12'h000, 8'h08);
      comparator_raw <= 1'b1;
      repeat (2) @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h0);
      cmp({31'h0, hysteresis_enable}, 32'h1);
      @(posedge pclk);
      comparator_above_upper <= 1'b1;
      comparator_raw <= 1'b0;
      @(posedge pclk);
      comparator_above_upper <= 1'b0;
      repeat (2) @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h1);
      @(posedge pclk);
      rd_chk(12'h00C, {26'h0, 1'b0, rf[4] | fast_internal_oscillator, 4'hE}, 1'b0);
      @(posedge pclk);
      comparator_below_lower <= 1'b1;
      repeat (2) @(negedge pclk);
      cmp({31'h0, comparator_synced}, 32'h0);
      $display("test hysteresis done");
      print_verdict();
   end
endmodule : testbench
